// ### hdl/tlb_lookup_load.sv
`timescale 1ns/1ps
`include "tlb_params.svh"

// What this block does
// - Four ways of 32 entries each
// - Compare all four indexed ways in parallel
// - Hit needs match and valid flag set
// - Page bits 11:10 compared only for small pages
// - Process id compared only for unshared entries
// - Single-memory privileged mode skips process id
// - Permitted write to clean page raises first-write exception
// - Cacheable flag selects cached access, never faults
// - Decode two-bit access right field
// - Disallowed access raises protection violation
// - Translation disabled means no translation, no exceptions
// - Flush clears all valid flags, reads zero
// - Entries loaded by instruction or mapped access
// - Index mode 0 loads at page bits 16:12
// - Index mode 1 xors page and process bits
// - Exception loads faulting page into high register
// - Replacement way update on miss or fault
module tlb_lookup_load (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // Core access request
  input  wire logic        access_valid_in,
  input  wire logic [21:0] access_vpn_in,
  input  wire logic        access_write_in,
  input  wire logic        privileged_mode_bit_in,
  input  wire logic        load_entry_instruction_in,
  // Lookup result
  output logic             result_valid_out,
  output logic             result_translated_out,
  output logic             result_hit_out,
  output logic [18:0]      result_ppn_out,
  output logic             result_cacheable_out,
  output logic             result_miss_exc_out,
  output logic             result_invalid_exc_out,
  output logic             result_prot_exc_out,
  output logic             result_first_write_exc_out,
  output logic [1:0]       result_way_out,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);

  localparam int NUM_WAYS = 4;
  localparam int IDX_W    = 5;

  tlb_pkg::tlb_state_t st;
  tlb_pkg::tlb_state_t next_st;
  tlb_pkg::tlb_entry_t set_rd [NUM_WAYS];
  tlb_pkg::tlb_entry_t mm_rd;
  tlb_pkg::tlb_entry_t wr_entry;
  logic                wr_en;
  logic [1:0]          wr_way;
  logic [4:0]          wr_idx;
  logic                flush;
  logic [4:0]          lookup_idx;
  logic [NUM_WAYS-1:0] way_match;
  logic [NUM_WAYS-1:0] way_hit;

  // Lookup index from page bits 16:12, optionally mixed with process id
  assign lookup_idx = st.index_mode_bit ? (access_vpn_in[6:2] ^ st.high_pid[4:0])
                                        : access_vpn_in[6:2];

  tlb_entry_store #(
    .NUM_WAYS (NUM_WAYS),
    .IDX_W    (IDX_W)
  ) u_store (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .wr_en_in      (wr_en),
    .wr_way_in     (wr_way),
    .wr_idx_in     (wr_idx),
    .wr_entry_in   (wr_entry),
    .flush_in      (flush),
    .lookup_idx_in (lookup_idx),
    .lookup_set_out(set_rd),
    .mm_way_in     (st.sel_way),
    .mm_idx_in     (st.sel_idx),
    .mm_entry_out  (mm_rd)
  );

  genvar w;
  generate
    for (w = 0; w < NUM_WAYS; w++) begin : g_cmp
      logic vpn_eq;
      logic pid_ok;
      // Bits 11:10 only matter for small pages
      assign vpn_eq = (set_rd[w].virtual_page_number[21:2] == access_vpn_in[21:2]) &&
                      (set_rd[w].page_size_flag ||
                       (set_rd[w].virtual_page_number[1:0] == access_vpn_in[1:0]));
      assign pid_ok = set_rd[w].shared_flag ||
                      (st.single_virtual_memory_bit && privileged_mode_bit_in) ||
                      (set_rd[w].process_identifier == st.high_pid);
      assign way_match[w] = vpn_eq && pid_ok;
      assign way_hit[w]   = way_match[w] && set_rd[w].valid;
    end
  endgenerate

  function automatic logic [31:0] low_word(input tlb_pkg::tlb_entry_t e);
    logic [31:0] r;
    r = '0;
    r[`TLB_LO_PPN_HI:`TLB_LO_PPN_LO] = e.physical_page_number;
    r[`TLB_LO_V]                     = e.valid;
    r[`TLB_LO_PR_HI:`TLB_LO_PR_LO]   = e.access_right_field;
    r[`TLB_LO_SZ]                    = e.page_size_flag;
    r[`TLB_LO_C]                     = e.cacheable;
    r[`TLB_LO_D]                     = e.dirty;
    r[`TLB_LO_SH]                    = e.shared_flag;
    return r;
  endfunction : low_word

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  // Register readback; also the base of byte-masked writes
  function automatic logic [31:0] read_word(input tlb_pkg::tlb_state_t s,
                                            input tlb_pkg::tlb_entry_t e,
                                            input logic [7:0] addr,
                                            output logic mapped);
    logic [31:0] r;
    r      = '0;
    mapped = 1'b1;
    unique case (addr)
      `TLB_OFS_CTRL: begin
        r[`TLB_CTRL_AT]                    = s.translation_enable_bit;
        r[`TLB_CTRL_IX]                    = s.index_mode_bit;
        r[`TLB_CTRL_RC_HI:`TLB_CTRL_RC_LO] = s.replacement_way_field;
        r[`TLB_CTRL_SV]                    = s.single_virtual_memory_bit;
      end
      `TLB_OFS_PAGE_ENTRY_HIGH_REG: begin
        r[`TLB_HI_VPN_HI:`TLB_HI_VPN_LO] = s.high_vpn;
        r[`TLB_HI_PROCESS_IDENTIFIER_HI:0]             = s.high_pid;
      end
      `TLB_OFS_PAGE_ENTRY_LOW_REG: r = s.page_entry_low_reg;
      `TLB_OFS_SEL: begin
        r[`TLB_SEL_WAY_HI:`TLB_SEL_WAY_LO] = s.sel_way;
        r[`TLB_SEL_IDX_HI:0]               = s.sel_idx;
      end
      `TLB_OFS_MM_ADDR: begin
        r[`TLB_HI_VPN_HI:`TLB_HI_VPN_LO] = e.virtual_page_number;
        r[`TLB_LO_V]                     = e.valid;
        r[`TLB_HI_PROCESS_IDENTIFIER_HI:0]             = e.process_identifier;
      end
      `TLB_OFS_MM_DATA: begin
        r           = low_word(e);
        r[`TLB_LO_V] = 1'b0;
      end
      default: mapped = 1'b0;
    endcase
    return r;
  endfunction : read_word

  always_comb begin
    logic [31:0]         m;
    logic                mapped;
    logic                entry_target;
    logic                allowed;
    logic                found;
    logic                any_match;
    logic                all_valid;
    logic [1:0]          fw;
    logic [1:0]          mw;
    logic [1:0]          iw;
    tlb_pkg::tlb_entry_t e;
    m            = '0;
    mapped       = 1'b0;
    entry_target = 1'b0;
    allowed      = 1'b0;
    found        = 1'b0;
    any_match    = 1'b0;
    all_valid    = 1'b1;
    fw           = '0;
    mw           = '0;
    iw           = '0;
    e            = mm_rd;
    next_st      = st;
    wr_en        = 1'b0;
    wr_way       = '0;
    wr_idx       = '0;
    wr_entry     = '0;
    flush        = 1'b0;

    // Address and data channels accepted independently
    if (s_axi_awvalid_in && st.aw_ready) begin
      next_st.aw_ready = 1'b0;
      next_st.aw_full  = 1'b1;
      next_st.aw_addr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && st.w_ready) begin
      next_st.w_ready = 1'b0;
      next_st.w_full  = 1'b1;
      next_st.w_data  = s_axi_wdata_in;
      next_st.w_strb  = s_axi_wstrb_in;
    end
    if (st.b_valid && s_axi_bready_in) begin
      next_st.b_valid  = 1'b0;
      next_st.aw_ready = 1'b1;
      next_st.w_ready  = 1'b1;
    end

    // Entry writes wait while the load instruction owns the write port
    entry_target = (st.aw_addr == `TLB_OFS_MM_ADDR) || (st.aw_addr == `TLB_OFS_MM_DATA);
    if (st.aw_full && st.w_full && !(entry_target && load_entry_instruction_in)) begin
      m = byte_merge(read_word(st, mm_rd, st.aw_addr, mapped), st.w_data, st.w_strb);
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.b_valid = 1'b1;
      next_st.b_resp  = mapped ? `TLB_RESP_OKAY : `TLB_RESP_SLVERR;
      unique case (st.aw_addr)
        `TLB_OFS_CTRL: begin
          next_st.translation_enable_bit    = m[`TLB_CTRL_AT];
          next_st.index_mode_bit            = m[`TLB_CTRL_IX];
          next_st.replacement_way_field     = m[`TLB_CTRL_RC_HI:`TLB_CTRL_RC_LO];
          next_st.single_virtual_memory_bit = m[`TLB_CTRL_SV];
          flush = st.w_strb[0] && st.w_data[`TLB_CTRL_TF];
        end
        `TLB_OFS_PAGE_ENTRY_HIGH_REG: begin
          next_st.high_vpn = m[`TLB_HI_VPN_HI:`TLB_HI_VPN_LO];
          next_st.high_pid = m[`TLB_HI_PROCESS_IDENTIFIER_HI:0];
        end
        `TLB_OFS_PAGE_ENTRY_LOW_REG: next_st.page_entry_low_reg = m & low_word('1);
        `TLB_OFS_SEL: begin
          next_st.sel_way = m[`TLB_SEL_WAY_HI:`TLB_SEL_WAY_LO];
          next_st.sel_idx = m[`TLB_SEL_IDX_HI:0];
        end
        `TLB_OFS_MM_ADDR: begin
          // Writing valid low here deletes the entry
          e.virtual_page_number = m[`TLB_HI_VPN_HI:`TLB_HI_VPN_LO];
          e.valid               = m[`TLB_LO_V];
          e.process_identifier  = m[`TLB_HI_PROCESS_IDENTIFIER_HI:0];
          wr_en = 1'b1;
        end
        `TLB_OFS_MM_DATA: begin
          e.physical_page_number = m[`TLB_LO_PPN_HI:`TLB_LO_PPN_LO];
          e.access_right_field   = m[`TLB_LO_PR_HI:`TLB_LO_PR_LO];
          e.page_size_flag       = m[`TLB_LO_SZ];
          e.cacheable            = m[`TLB_LO_C];
          e.dirty                = m[`TLB_LO_D];
          e.shared_flag          = m[`TLB_LO_SH];
          wr_en = 1'b1;
        end
        default: ;
      endcase
      wr_way   = st.sel_way;
      wr_idx   = st.sel_idx;
      wr_entry = e;
    end

    // Read channel
    if (s_axi_arvalid_in && st.ar_ready) begin
      next_st.ar_ready = 1'b0;
      next_st.r_valid  = 1'b1;
      next_st.r_data   = read_word(st, mm_rd, s_axi_araddr_in, mapped);
      next_st.r_resp   = mapped ? `TLB_RESP_OKAY : `TLB_RESP_SLVERR;
    end
    if (st.r_valid && s_axi_rready_in) begin
      next_st.r_valid  = 1'b0;
      next_st.ar_ready = 1'b1;
    end

    // Lowest hitting way wins; lowest invalid way for replacement
    for (int i = NUM_WAYS - 1; i >= 0; i--) begin
      if (way_hit[i]) begin
        found = 1'b1;
        fw    = i[1:0];
      end
      if (way_match[i]) begin
        any_match = 1'b1;
        mw        = i[1:0];
      end
      if (!set_rd[i].valid) begin
        all_valid = 1'b0;
        iw        = i[1:0];
      end
    end

    // Lookup result, one per access
    next_st.res_valid       = access_valid_in;
    next_st.res_translated  = 1'b0;
    next_st.res_hit         = 1'b0;
    next_st.res_ppn         = access_vpn_in[18:0];
    next_st.res_cacheable   = 1'b0;
    next_st.res_miss        = 1'b0;
    next_st.res_invalid     = 1'b0;
    next_st.res_prot        = 1'b0;
    next_st.res_first_write = 1'b0;
    next_st.res_way         = '0;
    if (access_valid_in && st.translation_enable_bit) begin
      next_st.res_translated = 1'b1;
      if (found) begin
        unique case ({privileged_mode_bit_in, access_write_in})
          2'h2:    allowed = 1'b1;
          2'h3:    allowed = set_rd[fw].access_right_field[0];
          2'h0:    allowed = set_rd[fw].access_right_field[1];
          default: allowed = &set_rd[fw].access_right_field;
        endcase
        next_st.res_hit       = 1'b1;
        next_st.res_way       = fw;
        next_st.res_ppn       = set_rd[fw].page_size_flag ?
                                {set_rd[fw].physical_page_number[18:2], access_vpn_in[1:0]} :
                                set_rd[fw].physical_page_number;
        next_st.res_cacheable = set_rd[fw].cacheable;
        next_st.res_prot      = !allowed;
        next_st.res_first_write = allowed && access_write_in && !set_rd[fw].dirty;
        if (!allowed || (access_write_in && !set_rd[fw].dirty)) begin
          next_st.high_vpn              = access_vpn_in;
          next_st.replacement_way_field = fw;
        end
      end else if (any_match) begin
        next_st.res_invalid           = 1'b1;
        next_st.res_way               = mw;
        next_st.high_vpn              = access_vpn_in;
        next_st.replacement_way_field = mw;
      end else begin
        next_st.res_miss              = 1'b1;
        next_st.high_vpn              = access_vpn_in;
        next_st.replacement_way_field = all_valid ? (st.replacement_way_field + 2'h1) : iw;
      end
    end

    // Load instruction writes high and low registers into the chosen way
    if (load_entry_instruction_in) begin
      wr_en    = 1'b1;
      wr_way   = st.replacement_way_field;
      wr_idx   = st.index_mode_bit ? (st.high_vpn[6:2] ^ st.high_pid[4:0])
                                   : st.high_vpn[6:2];
      wr_entry.virtual_page_number  = st.high_vpn;
      wr_entry.process_identifier   = st.high_pid;
      wr_entry.valid                = st.page_entry_low_reg[`TLB_LO_V];
      wr_entry.physical_page_number = st.page_entry_low_reg[`TLB_LO_PPN_HI:`TLB_LO_PPN_LO];
      wr_entry.access_right_field   = st.page_entry_low_reg[`TLB_LO_PR_HI:`TLB_LO_PR_LO];
      wr_entry.page_size_flag       = st.page_entry_low_reg[`TLB_LO_SZ];
      wr_entry.cacheable            = st.page_entry_low_reg[`TLB_LO_C];
      wr_entry.dirty                = st.page_entry_low_reg[`TLB_LO_D];
      wr_entry.shared_flag          = st.page_entry_low_reg[`TLB_LO_SH];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st                       <= '0;
      st.replacement_way_field <= `TLB_RST_RC;
      st.aw_ready              <= `TLB_RST_READY;
      st.w_ready               <= `TLB_RST_READY;
      st.ar_ready              <= `TLB_RST_READY;
    end else begin
      st <= next_st;
    end
  end

  assign result_valid_out           = st.res_valid;
  assign result_translated_out      = st.res_translated;
  assign result_hit_out             = st.res_hit;
  assign result_ppn_out             = st.res_ppn;
  assign result_cacheable_out       = st.res_cacheable;
  assign result_miss_exc_out        = st.res_miss;
  assign result_invalid_exc_out     = st.res_invalid;
  assign result_prot_exc_out        = st.res_prot;
  assign result_first_write_exc_out = st.res_first_write;
  assign result_way_out             = st.res_way;
  assign s_axi_awready_out          = st.aw_ready;
  assign s_axi_wready_out           = st.w_ready;
  assign s_axi_bresp_out            = st.b_resp;
  assign s_axi_bvalid_out           = st.b_valid;
  assign s_axi_arready_out          = st.ar_ready;
  assign s_axi_rdata_out            = st.r_data;
  assign s_axi_rresp_out            = st.r_resp;
  assign s_axi_rvalid_out           = st.r_valid;

endmodule : tlb_lookup_load

// ### hdl/tlb_params.svh
`ifndef TLB_PARAMS_SVH
`define TLB_PARAMS_SVH

// Register byte offsets
`define TLB_OFS_CTRL      8'h00
`define TLB_OFS_PAGE_ENTRY_HIGH_REG      8'h04
`define TLB_OFS_PAGE_ENTRY_LOW_REG      8'h08
`define TLB_OFS_SEL       8'h0c
`define TLB_OFS_MM_ADDR   8'h10
`define TLB_OFS_MM_DATA   8'h14

// Control register fields
`define TLB_CTRL_AT       0
`define TLB_CTRL_IX       1
`define TLB_CTRL_TF       2
`define TLB_CTRL_RC_LO    4
`define TLB_CTRL_RC_HI    5
`define TLB_CTRL_SV       8

// Entry low word fields
`define TLB_LO_SH         1
`define TLB_LO_D          2
`define TLB_LO_C          3
`define TLB_LO_SZ         4
`define TLB_LO_PR_LO      5
`define TLB_LO_PR_HI      6
`define TLB_LO_V          8
`define TLB_LO_PPN_LO     10
`define TLB_LO_PPN_HI     28

// Entry high word fields
`define TLB_HI_PROCESS_IDENTIFIER_HI    7
`define TLB_HI_VPN_LO     10
`define TLB_HI_VPN_HI     31

// Entry select register fields
`define TLB_SEL_IDX_HI    4
`define TLB_SEL_WAY_LO    8
`define TLB_SEL_WAY_HI    9

// Reset values
`define TLB_RST_READY     1'b1
`define TLB_RST_RC        2'h0

// Bus responses
`define TLB_RESP_OKAY     2'h0
`define TLB_RESP_SLVERR   2'h2

`endif

// ### hdl/tlb_pkg.sv
package tlb_pkg;

  typedef struct packed {
    logic [21:0] virtual_page_number;
    logic [7:0]  process_identifier;
    logic        valid;
    logic [18:0] physical_page_number;
    logic [1:0]  access_right_field;
    logic        page_size_flag;
    logic        cacheable;
    logic        dirty;
    logic        shared_flag;
  } tlb_entry_t;

  typedef struct packed {
    logic        translation_enable_bit;
    logic        index_mode_bit;
    logic        single_virtual_memory_bit;
    logic [1:0]  replacement_way_field;
    logic [21:0] high_vpn;
    logic [7:0]  high_pid;
    logic [31:0] page_entry_low_reg;
    logic [1:0]  sel_way;
    logic [4:0]  sel_idx;
    logic        aw_ready;
    logic        w_ready;
    logic        ar_ready;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    logic        res_valid;
    logic        res_translated;
    logic        res_hit;
    logic [18:0] res_ppn;
    logic        res_cacheable;
    logic        res_miss;
    logic        res_invalid;
    logic        res_prot;
    logic        res_first_write;
    logic [1:0]  res_way;
  } tlb_state_t;

endpackage : tlb_pkg

// ### hdl/tlb_entry_store.sv
`timescale 1ns/1ps
`include "tlb_params.svh"

module tlb_entry_store #(
  parameter int NUM_WAYS = 4,
  parameter int IDX_W    = 5
) (
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_n_in,
  // Write port and flush
  input  wire logic                        wr_en_in,
  input  wire logic [$clog2(NUM_WAYS)-1:0] wr_way_in,
  input  wire logic [IDX_W-1:0]            wr_idx_in,
  input  tlb_pkg::tlb_entry_t              wr_entry_in,
  input  wire logic                        flush_in,
  // Lookup read port, all ways of one set
  input  wire logic [IDX_W-1:0]            lookup_idx_in,
  output tlb_pkg::tlb_entry_t              lookup_set_out [NUM_WAYS],
  // Single entry read port
  input  wire logic [$clog2(NUM_WAYS)-1:0] mm_way_in,
  input  wire logic [IDX_W-1:0]            mm_idx_in,
  output tlb_pkg::tlb_entry_t              mm_entry_out
);

  localparam int WAY_W = $clog2(NUM_WAYS);
  localparam int DEPTH = NUM_WAYS * (2 ** IDX_W);

  typedef struct packed {
    tlb_pkg::tlb_entry_t [DEPTH-1:0] ent;
  } tlb_store_t;

  tlb_store_t st;
  tlb_store_t next_st;

  genvar w;
  generate
    for (w = 0; w < NUM_WAYS; w++) begin : g_way
      // Every way of the indexed set is read at once
      assign lookup_set_out[w] = st.ent[{WAY_W'(w), lookup_idx_in}];
    end
  endgenerate

  assign mm_entry_out = st.ent[{mm_way_in, mm_idx_in}];

  always_comb begin
    next_st = st;
    if (wr_en_in) begin
      next_st.ent[{wr_way_in, wr_idx_in}] = wr_entry_in;
    end
    if (flush_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        next_st.ent[i].valid = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : tlb_entry_store

// ### testbench/tlb_lookup_load_props.sv
`timescale 1ns/1ps
module tlb_lookup_load_props (
  // Clock, reset and core side
  input wire logic core_clk_in, rst_n_in, access_valid_in, access_write_in,
  input wire logic privileged_mode_bit_in, result_valid_out, result_translated_out,
  input wire logic result_hit_out, result_cacheable_out, result_miss_exc_out,
  input wire logic result_invalid_exc_out, result_prot_exc_out, result_first_write_exc_out,
  // Read handshake
  input wire logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire [3:0] exc = {result_miss_exc_out, result_invalid_exc_out,
                    result_prot_exc_out, result_first_write_exc_out};
  a_answer_next: assert property (access_valid_in |=> result_valid_out)
    else $error("lookup result missing");
  a_no_spurious: assert property (!access_valid_in |=> !result_valid_out)
    else $error("result without access");
  a_off_quiet: assert property (!result_translated_out |-> exc == 4'h0)
    else $error("exception while untranslated");
  a_exc_valid: assert property (exc != 4'h0 |-> result_valid_out)
    else $error("exception outside result");
  a_exc_single: assert property (result_valid_out |-> $onehot0(exc))
    else $error("several exceptions at once");
  a_hit_clean: assert property (result_hit_out |-> exc[3:2] == 2'h0)
    else $error("hit with miss or invalid");
  a_first_write: assert property (result_first_write_exc_out |-> $past(access_write_in))
    else $error("first write on a read");
  a_priv_read: assert property (result_prot_exc_out && $past(privileged_mode_bit_in)
    |-> $past(access_write_in))
    else $error("privileged read refused");
  a_cache_hit: assert property (result_cacheable_out |-> result_hit_out)
    else $error("cacheable without hit");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
endmodule : tlb_lookup_load_props
bind tlb_lookup_load tlb_lookup_load_props u_props (.*);

// ### testbench/tlb_core_model.sv
`timescale 1ns/1ps
module tlb_core_model (
  input  wire logic   core_clk_in,
  // Core requests
  output logic        access_valid_in,
  output logic [21:0] access_vpn_in,
  output logic        access_write_in,
  output logic        privileged_mode_bit_in,
  output logic        load_entry_instruction_in
);
  initial begin
    {access_valid_in, access_vpn_in, access_write_in} = '0;
    {privileged_mode_bit_in, load_entry_instruction_in} = '0;
  end
  task automatic acc(input logic [21:0] v, input logic w, input logic p);
    @(posedge core_clk_in);
    {access_valid_in, access_vpn_in, access_write_in, privileged_mode_bit_in} <= {1'b1, v, w, p};
    @(posedge core_clk_in);
    access_valid_in <= 1'b0;
    access_vpn_in <= ~v;
  endtask : acc
  task automatic load();
    @(posedge core_clk_in);
    load_entry_instruction_in <= 1'b1;
    @(posedge core_clk_in);
    load_entry_instruction_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask : load
endmodule : tlb_core_model

// ### testbench/tlb_lookup_load_bench.sv
`timescale 1ns/1ps
module tlb_lookup_load_bench;
  logic core_clk_in, rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, result_valid_out;
  logic result_translated_out, result_hit_out, result_cacheable_out, result_miss_exc_out;
  logic result_invalid_exc_out, result_prot_exc_out, result_first_write_exc_out;
  logic access_valid_in, access_write_in, privileged_mode_bit_in, load_entry_instruction_in;
  logic [21:0] access_vpn_in;
  logic [18:0] result_ppn_out;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rq;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, result_way_out, resp;
  int error_cnt = 0;
  int cmp_count = 0;
  localparam logic [21:0] VPG = 22'h000014;
  tlb_lookup_load DUT (.*);
  tlb_core_model core (.*);
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge core_clk_in);
    {s_axi_awaddr_in, s_axi_wdata_in} <= {a, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    do begin
      @(negedge core_clk_in);
      {aw, w, b, resp} = {s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_bresp_out};
      @(posedge core_clk_in);
      if (aw) s_axi_awvalid_in <= 1'b0;
      if (w) s_axi_wvalid_in <= 1'b0;
    end while (!b);
    s_axi_bready_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic ar, r;
    @(posedge core_clk_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    do begin
      @(negedge core_clk_in);
      {ar, r, rq, resp} = {s_axi_arready_out, s_axi_rvalid_out, s_axi_rdata_out, s_axi_rresp_out};
      @(posedge core_clk_in);
      if (ar) s_axi_arvalid_in <= 1'b0;
    end while (!r);
    s_axi_rready_in <= 1'b0;
    chk(rq, e);
  endtask : rd
  // Expected {translated, miss, invalid, protection, first write}
  task automatic look(input logic [21:0] v, input logic w, input logic p, input logic [4:0] e);
    core.acc(v, w, p);
    @(negedge core_clk_in);
    chk(result_valid_out, 1'b1);
    chk({result_translated_out, result_miss_exc_out, result_invalid_exc_out,
         result_prot_exc_out, result_first_write_exc_out}, e);
  endtask : look
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge core_clk_in);
    error_cnt++;
    finish_test();
  end
  initial begin
    logic ok;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    s_axi_wstrb_in = 4'hf;
    rst_n_in = 1'b0;
    repeat (10) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h0);
    chk(resp, 2'h2);
    look(VPG, 1'b0, 1'b1, 5'h00);
    chk(result_ppn_out, 19'h00014);
    wr(8'h00, 32'h1);
    chk(resp, 2'h0);
    wr(8'h04, 32'h5005);
    wr(8'h08, 32'h48d6c);
    core.load();
    look(VPG, 1'b1, 1'b0, 5'h10);
    chk({result_hit_out, result_cacheable_out, result_way_out, result_ppn_out},
        {2'h3, 2'h0, 19'h00123});
    look(VPG ^ 22'h1, 1'b0, 1'b0, 5'h18);
    rd(8'h00, 32'h11);
    rd(8'h04, 32'h5405);
    wr(8'h00, 32'h105);
    rd(8'h00, 32'h101);
    look(VPG, 1'b0, 1'b1, 5'h14);
    core.load();
    wr(8'h04, 32'h5006);
    look(VPG, 1'b0, 1'b1, 5'h10);
    look(VPG, 1'b0, 1'b0, 5'h18);
    wr(8'h04, 32'h5005);
    wr(8'h0c, 32'h5);
    for (int pr = 0; pr < 4; pr++) begin
      wr(8'h14, 32'h48c0c | (pr << 5));
      for (int m = 0; m < 4; m++) begin
        ok = m[1] ? pr[0] && (pr[1] || m[0]) : (m[0] || pr[1]);
        look(VPG, m[1], m[0], {3'h4, !ok, 1'b0});
      end
    end
    wr(8'h14, 32'h48c68);
    look(VPG, 1'b1, 1'b0, 5'h11);
    look(VPG, 1'b0, 1'b0, 5'h10);
    wr(8'h04, 32'h5006);
    wr(8'h14, 32'h48c7e);
    look(VPG ^ 22'h1, 1'b1, 1'b0, 5'h10);
    chk(result_ppn_out, 19'h00121);
    wr(8'h04, 32'h5005);
    wr(8'h10, 32'h5005);
    look(VPG, 1'b0, 1'b0, 5'h14);
    rd(8'h10, 32'h5005);
    wr(8'h00, 32'h7);
    wr(8'h08, 32'h48d6c);
    core.load();
    look(VPG, 1'b0, 1'b0, 5'h10);
    wr(8'h0c, 32'h0);
    rd(8'h10, 32'h5105);
    finish_test();
  end
endmodule : tlb_lookup_load_bench
